// ---- hw/usc_pkg.sv ----
//-----------------------------------------------------------------------------
// Purpose: constants and types shared by the serial status/control block
// Assumes: 16-bit register port, one clock
// Notes: bit times are counted in clock cycles
//-----------------------------------------------------------------------------
package usc_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 16;
	localparam int CHAR_W = 8;
	localparam int FIFO_DEPTH = 4;
	localparam int PTR_W = 2;
	localparam int CNT_W = 3;
	localparam int TICK_W = 8;
	localparam int IRQ_W = 3;

	// register offsets
	localparam logic [ADDR_W-1:0] ADR_STA = 3'h0;
	localparam logic [ADDR_W-1:0] ADR_TXD = 3'h1;
	localparam logic [ADDR_W-1:0] ADR_RXD = 3'h2;
	localparam logic [ADDR_W-1:0] ADR_IST = 3'h3;
	localparam logic [ADDR_W-1:0] ADR_IMSK = 3'h4;
	localparam logic [ADDR_W-1:0] ADR_CFG = 3'h5;

	// serial_status_control field positions, then the config register encode-enable bit
	localparam int B_TXISEL1 = 15;
	localparam int B_TXINV = 14;
	localparam int B_TXISEL0 = 13;
	localparam int B_RSVD12 = 12;
	localparam int B_TXBRK = 11;
	localparam int B_TXEN = 10;
	localparam int B_TXBF = 9;
	localparam int B_TX_SHIFT_EMPTY = 8;
	localparam int B_RXISEL1 = 7;
	localparam int B_RXISEL0 = 6;
	localparam int B_RIDLE = 4;
	localparam int B_RX_OVERRUN_FLAG = 1;
	localparam int B_RXDA = 0;
	localparam int B_INFRARED_ENCODE_ENABLE = 0;

	// interrupt status bits
	localparam int IRQ_TX = 0;
	localparam int IRQ_RX = 1;
	localparam int IRQ_OVR = 2;

	// transmit interrupt modes
	localparam logic [1:0] TXI_LOAD = 2'h0;
	localparam logic [1:0] TXI_DONE = 2'h1;
	localparam logic [1:0] TXI_EMPTY = 2'h2;

	// bit timing in clock cycles
	localparam logic [TICK_W-1:0] BIT_LAST = 8'h0f;
	localparam logic [TICK_W-1:0] BIT_HALF = 8'h07;
	localparam logic [TICK_W-1:0] IR_PULSE = 8'h04;

	// frame shapes, lsb first, and buffer levels
	localparam logic [3:0] FRAME_BITS = 4'ha;
	localparam logic [3:0] BREAK_BITS = 4'he;
	localparam logic [3:0] RX_STOP_IDX = 4'h9;
	localparam logic [13:0] BREAK_FRAME = 14'h2000;
	localparam logic [CNT_W-1:0] TX_LVL_1 = 3'h1;
	localparam logic [CNT_W-1:0] RX_LVL_3 = 3'h3;
	localparam logic [CNT_W-1:0] RX_LVL_4 = 3'h4;

	typedef enum logic {TX_IDLE, TX_SHIFT} usc_tx_state_t;
	typedef enum logic {RX_IDLE, RX_RUN} usc_rx_state_t;
endpackage

// ---- hw/usc_fifo.sv ----
//-----------------------------------------------------------------------------
// Purpose: four-entry character buffer
// Assumes: push when full and pop when empty are ignored
// Notes: read data come straight from the storage flops
//-----------------------------------------------------------------------------
`timescale 1ns/100ps
module usc_fifo (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic flush,
	input wire logic push,
	input wire logic [usc_pkg::CHAR_W-1:0] push_data,
	input wire logic pop,
	output logic [usc_pkg::CHAR_W-1:0] pop_data,
	output logic full,
	output logic empty,
	output logic [usc_pkg::CNT_W-1:0] count
);
	import usc_pkg::*;

	logic [CHAR_W-1:0] mem_q [FIFO_DEPTH];
	logic [CHAR_W-1:0] mem_d [FIFO_DEPTH];
	logic [PTR_W-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic do_push, do_pop;

	assign full = (cnt_q == CNT_W'(FIFO_DEPTH));
	assign empty = (cnt_q == '0);
	assign count = cnt_q;
	assign pop_data = mem_q[rptr_q];
	assign do_push = push && !full;
	assign do_pop = pop && !empty;

	// pointer and count update
	always_comb begin
		mem_d = mem_q;
		wptr_d = wptr_q;
		rptr_d = rptr_q;
		cnt_d = cnt_q;
		if (flush) begin
			wptr_d = '0;
			rptr_d = '0;
			cnt_d = '0;
		end else begin
			if (do_push) begin
				mem_d[wptr_q] = push_data;
				wptr_d = wptr_q + 2'h1;
			end
			if (do_pop) begin
				rptr_d = rptr_q + 2'h1;
			end
			cnt_d = cnt_q + CNT_W'(do_push) - CNT_W'(do_pop);
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < FIFO_DEPTH; i++) begin
				mem_q[i] <= '0;
			end
			wptr_q <= '0;
			rptr_q <= '0;
			cnt_q <= '0;
		end else begin
			mem_q <= mem_d;
			wptr_q <= wptr_d;
			rptr_q <= rptr_d;
			cnt_q <= cnt_d;
		end
	end
endmodule

// ---- hw/usc_top.sv ----
//-----------------------------------------------------------------------------
// Purpose: serial port status/control, transmitter, receiver, interrupts
// Assumes: 8 data bits, one stop bit, fixed bit time, 250 MHz clk
// Notes: registers on a plain strobe port, read data one cycle after strobe
//-----------------------------------------------------------------------------
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
// How it works
// - tx mode 10: event when a load into shifter empties the buffer
// - tx mode 01: event when the last character finished shifting out
// - tx mode 00: event on every load of a character from the buffer into the shift register; break loads raise none
// - no infrared: polarity set idles line low, cleared idles high
// - infrared: polarity set idles high, cleared idles low
// - break request sends start, twelve zeros, stop, then self-clears
// - transmit enable hands the pin to the port and lets sending run
// - clearing transmit enable aborts sending, flushes buffer, frees pin
// - buffer-full flag is one when no further character fits
// - shift-empty flag one only when shifter and buffer are both empty
// - rx mode 11: event when a transfer makes the buffer hold four
// - rx mode 10: event when a transfer makes the buffer hold three
// - rx mode 0x: event on every transfer into the receive buffer
// - bit 12 of the status/control register always reads zero
module usc_top (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [usc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [usc_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [usc_pkg::DATA_W-1:0] reg_rdata,
	input wire logic serial_rx_pin,
	output logic serial_tx_pin,
	output logic serial_tx_oe,
	output logic irq
);
	import usc_pkg::*;

	//-------------------------------------------------------------------------
	// control state
	//-------------------------------------------------------------------------
	logic [1:0] txisel_q, txisel_d, rxisel_q, rxisel_d;
	logic inv_q, inv_d, brk_q, brk_d, txen_q, txen_d, infrared_encode_enable_q, infrared_encode_enable_d;
	logic rx_overrun_flag_q, rx_overrun_flag_d;
	logic [IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d, ev;
	logic [DATA_W-1:0] rdata_q, rdata_d, sta;
	logic wr_sta, wr_txd, rd_rxd;

	// transmit path
	usc_tx_state_t tx_state_q, tx_state_d;
	logic [13:0] tx_sr_q, tx_sr_d;
	logic [3:0] tx_left_q, tx_left_d;
	logic [TICK_W-1:0] tx_tick_q, tx_tick_d;
	logic tx_brk_q, tx_brk_d, pin_q, pin_d;
	logic txf_pop, txf_full, txf_empty, frame_done, brk_done, line_bit, ir_pulse;
	logic [CHAR_W-1:0] txf_data;
	logic [CNT_W-1:0] txf_cnt;

	// receive path
	usc_rx_state_t rx_state_q, rx_state_d;
	logic rx_s1_q, rx_s2_q;
	logic [TICK_W-1:0] rx_tick_q, rx_tick_d;
	logic [3:0] rx_idx_q, rx_idx_d;
	logic [CHAR_W-1:0] rx_sr_q, rx_sr_d, rxf_data;
	logic rx_done, rxf_full, rxf_empty;
	logic [CNT_W-1:0] rxf_cnt;

	assign wr_sta = reg_wr && (reg_addr == ADR_STA);
	assign wr_txd = reg_wr && (reg_addr == ADR_TXD);
	assign rd_rxd = reg_rd && (reg_addr == ADR_RXD);

	//-------------------------------------------------------------------------
	// buffers
	//-------------------------------------------------------------------------
	usc_fifo u_txf (
		.clk(clk),
		.sys_rst(sys_rst),
		.flush(!txen_q),
		.push(wr_txd),
		.push_data(reg_wdata[CHAR_W-1:0]),
		.pop(txf_pop),
		.pop_data(txf_data),
		.full(txf_full),
		.empty(txf_empty),
		.count(txf_cnt)
	);

	usc_fifo u_rxf (
		.clk(clk),
		.sys_rst(sys_rst),
		.flush(1'b0),
		.push(rx_done),
		.push_data(rx_sr_q),
		.pop(rd_rxd),
		.pop_data(rxf_data),
		.full(rxf_full),
		.empty(rxf_empty),
		.count(rxf_cnt)
	);

	//-------------------------------------------------------------------------
	// transmitter
	//-------------------------------------------------------------------------
	// load, shift and abort of the transmit frame
	always_comb begin
		tx_state_d = tx_state_q;
		tx_sr_d = tx_sr_q;
		tx_left_d = tx_left_q;
		tx_tick_d = tx_tick_q;
		tx_brk_d = tx_brk_q;
		txf_pop = 1'b0;
		frame_done = 1'b0;
		unique case (tx_state_q)
			TX_IDLE: begin
				if (txen_q && brk_q) begin
					tx_sr_d = BREAK_FRAME;
					tx_left_d = BREAK_BITS;
					tx_brk_d = 1'b1;
					tx_tick_d = '0;
					tx_state_d = TX_SHIFT;
				end else if (txen_q && !txf_empty) begin
					tx_sr_d = {5'h1f, txf_data, 1'b0};
					tx_left_d = FRAME_BITS;
					tx_brk_d = 1'b0;
					tx_tick_d = '0;
					txf_pop = 1'b1;
					tx_state_d = TX_SHIFT;
				end
			end
			TX_SHIFT: begin
				tx_tick_d = tx_tick_q + 8'h01;
				if (tx_tick_q == BIT_LAST) begin
					tx_tick_d = '0;
					tx_sr_d = {1'b1, tx_sr_q[13:1]};
					tx_left_d = tx_left_q - 4'h1;
					if (tx_left_q == 4'h1) begin
						frame_done = 1'b1;
						tx_state_d = TX_IDLE;
					end
				end
			end
		endcase
		if (!txen_q) begin
			tx_state_d = TX_IDLE;
			frame_done = 1'b0;
		end
	end

	assign brk_done = frame_done && tx_brk_q;
	assign line_bit = (tx_state_q == TX_SHIFT) ? tx_sr_q[0] : 1'b1;
	assign ir_pulse = !line_bit && (tx_tick_q < IR_PULSE);

	// pin level from polarity and encoding
	always_comb begin
		if (infrared_encode_enable_q) begin
			pin_d = inv_q ? !ir_pulse : ir_pulse;
		end else begin
			pin_d = line_bit ^ inv_q;
		end
	end

	assign serial_tx_pin = pin_q;
	assign serial_tx_oe = txen_q;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_state_q <= TX_IDLE;
			tx_sr_q <= '0;
			tx_left_q <= '0;
			tx_tick_q <= '0;
			tx_brk_q <= 1'b0;
			pin_q <= 1'b1;
		end else begin
			tx_state_q <= tx_state_d;
			tx_sr_q <= tx_sr_d;
			tx_left_q <= tx_left_d;
			tx_tick_q <= tx_tick_d;
			tx_brk_q <= tx_brk_d;
			pin_q <= pin_d;
		end
	end

	//-------------------------------------------------------------------------
	// receiver
	//-------------------------------------------------------------------------
	// start detect, mid-bit sampling, stop transfer into buffer
	always_comb begin
		rx_state_d = rx_state_q;
		rx_tick_d = rx_tick_q;
		rx_idx_d = rx_idx_q;
		rx_sr_d = rx_sr_q;
		rx_done = 1'b0;
		unique case (rx_state_q)
			RX_IDLE: begin
				if (!rx_s2_q) begin
					rx_tick_d = BIT_HALF;
					rx_idx_d = '0;
					rx_state_d = RX_RUN;
				end
			end
			RX_RUN: begin
				rx_tick_d = rx_tick_q - 8'h01;
				if (rx_tick_q == '0) begin
					rx_tick_d = BIT_LAST;
					rx_idx_d = rx_idx_q + 4'h1;
					if (rx_idx_q == '0 && rx_s2_q) begin
						rx_state_d = RX_IDLE;
					end else if (rx_idx_q == RX_STOP_IDX) begin
						rx_done = 1'b1;
						rx_state_d = RX_IDLE;
					end else if (rx_idx_q != '0) begin
						rx_sr_d = {rx_s2_q, rx_sr_q[CHAR_W-1:1]};
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
			rx_state_q <= RX_IDLE;
			rx_tick_q <= '0;
			rx_idx_q <= '0;
			rx_sr_q <= '0;
		end else begin
			rx_s1_q <= serial_rx_pin;
			rx_s2_q <= rx_s1_q;
			rx_state_q <= rx_state_d;
			rx_tick_q <= rx_tick_d;
			rx_idx_q <= rx_idx_d;
			rx_sr_q <= rx_sr_d;
		end
	end

	//-------------------------------------------------------------------------
	// events and registers
	//-------------------------------------------------------------------------
	// interrupt event sources by mode
	always_comb begin
		ev = '0;
		unique case (txisel_q)
			TXI_LOAD: ev[IRQ_TX] = txf_pop;
			// a write in the same cycle keeps the buffer from draining
			TXI_EMPTY: ev[IRQ_TX] = txf_pop && !wr_txd && (txf_cnt == TX_LVL_1);
			TXI_DONE: ev[IRQ_TX] = frame_done && txf_empty && !wr_txd;
			default: ev[IRQ_TX] = 1'b0;
		endcase
		if (!rxisel_q[1]) begin
			ev[IRQ_RX] = rx_done && !rxf_full;
		end else if (rxisel_q[0]) begin
			ev[IRQ_RX] = rx_done && !rd_rxd && (rxf_cnt == RX_LVL_3);
		end else begin
			ev[IRQ_RX] = rx_done && !rd_rxd && (rxf_cnt == TX_LVL_1 + TX_LVL_1);
		end
		ev[IRQ_OVR] = rx_done && rxf_full;
	end

	// status/control image
	always_comb begin
		sta = '0;
		sta[B_TXISEL1] = txisel_q[1];
		sta[B_TXINV] = inv_q;
		sta[B_TXISEL0] = txisel_q[0];
		sta[B_RSVD12] = 1'b0;
		sta[B_TXBRK] = brk_q;
		sta[B_TXEN] = txen_q;
		sta[B_TXBF] = txf_full;
		sta[B_TX_SHIFT_EMPTY] = (tx_state_q == TX_IDLE) && txf_empty;
		sta[B_RXISEL1] = rxisel_q[1];
		sta[B_RXISEL0] = rxisel_q[0];
		sta[B_RIDLE] = (rx_state_q == RX_IDLE);
		sta[B_RX_OVERRUN_FLAG] = rx_overrun_flag_q;
		sta[B_RXDA] = !rxf_empty;
	end

	// register writes, sticky bits and read mux
	always_comb begin
		txisel_d = txisel_q;
		rxisel_d = rxisel_q;
		inv_d = inv_q;
		txen_d = txen_q;
		infrared_encode_enable_d = infrared_encode_enable_q;
		imask_d = imask_q;
		brk_d = brk_done ? 1'b0 : brk_q;
		rx_overrun_flag_d = rx_overrun_flag_q;
		ist_d = ist_q;
		if (wr_sta) begin
			txisel_d = {reg_wdata[B_TXISEL1], reg_wdata[B_TXISEL0]};
			rxisel_d = {reg_wdata[B_RXISEL1], reg_wdata[B_RXISEL0]};
			inv_d = reg_wdata[B_TXINV];
			txen_d = reg_wdata[B_TXEN];
			brk_d = reg_wdata[B_TXBRK];
			if (!reg_wdata[B_RX_OVERRUN_FLAG]) begin
				rx_overrun_flag_d = 1'b0;
			end
		end
		if (reg_wr && reg_addr == ADR_IST) begin
			ist_d = ist_q & ~reg_wdata[IRQ_W-1:0];
		end
		if (reg_wr && reg_addr == ADR_IMSK) begin
			imask_d = reg_wdata[IRQ_W-1:0];
		end
		if (reg_wr && reg_addr == ADR_CFG) begin
			infrared_encode_enable_d = reg_wdata[B_INFRARED_ENCODE_ENABLE];
		end
		// set beats clear
		ist_d = ist_d | ev;
		rx_overrun_flag_d = rx_overrun_flag_d | ev[IRQ_OVR];
		rdata_d = '0;
		if (reg_rd) begin
			unique case (reg_addr)
				ADR_STA: rdata_d = sta;
				ADR_RXD: rdata_d = {8'h00, rxf_data};
				ADR_IST: rdata_d = {13'h0000, ist_q};
				ADR_IMSK: rdata_d = {13'h0000, imask_q};
				ADR_CFG: rdata_d = {15'h0000, infrared_encode_enable_q};
				default: rdata_d = '0;
			endcase
		end
	end

	assign reg_rdata = rdata_q;
	assign irq = |(ist_q & imask_q);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			txisel_q <= '0;
			rxisel_q <= '0;
			inv_q <= 1'b0;
			txen_q <= 1'b0;
			infrared_encode_enable_q <= 1'b0;
			imask_q <= '0;
			brk_q <= 1'b0;
			rx_overrun_flag_q <= 1'b0;
			ist_q <= '0;
			rdata_q <= '0;
		end else begin
			txisel_q <= txisel_d;
			rxisel_q <= rxisel_d;
			inv_q <= inv_d;
			txen_q <= txen_d;
			infrared_encode_enable_q <= infrared_encode_enable_d;
			imask_q <= imask_d;
			brk_q <= brk_d;
			rx_overrun_flag_q <= rx_overrun_flag_d;
			ist_q <= ist_d;
			rdata_q <= rdata_d;
		end
	end

	//-------------------------------------------------------------------------
	// assertions
	//-------------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_tx_mode_empty: assert property ((txf_pop && txf_cnt == TX_LVL_1 && !wr_txd && txisel_q == TXI_EMPTY)
		|=> ist_q[IRQ_TX]) else $error("tx empty-mode event missed");
	a_tx_mode_done: assert property ((txisel_q == TXI_DONE && txf_pop)
		|=> !ist_q[IRQ_TX] || $past(ist_q[IRQ_TX])) else $error("tx done-mode event too early");
	a_tx_mode_load: assert property ((txisel_q == TXI_LOAD && txf_pop)
		|=> ist_q[IRQ_TX]) else $error("tx load-mode event missed");
	a_idle_plain: assert property ((tx_state_q == TX_IDLE && !infrared_encode_enable_q) [*2]
		|-> serial_tx_pin == !$past(inv_q)) else $error("idle level wrong without encoding");
	a_idle_infra: assert property ((tx_state_q == TX_IDLE && infrared_encode_enable_q) [*2]
		|-> serial_tx_pin == $past(inv_q)) else $error("idle level wrong with encoding");
	a_break_clear: assert property ((brk_done && !wr_sta) |=> !brk_q)
		else $error("break request not cleared");
	a_pin_owner: assert property ((wr_sta && reg_wdata[B_TXEN]) |=> serial_tx_oe)
		else $error("pin not taken on enable");
	a_abort_flush: assert property ($fell(txen_q) |=> txf_empty && tx_state_q == TX_IDLE)
		else $error("abort left transmit state");
	a_full_flag: assert property ((reg_rd && reg_addr == ADR_STA)
		|=> reg_rdata[B_TXBF] == $past(txf_cnt == 3'h4)) else $error("buffer-full flag wrong");
	a_shift_empty: assert property ((reg_rd && reg_addr == ADR_STA && tx_state_q == TX_SHIFT)
		|=> !reg_rdata[B_TX_SHIFT_EMPTY]) else $error("shift-empty set while sending");
	a_rx_four: assert property ((rx_done && !rd_rxd && rxisel_q == 2'h3 && rxf_cnt == 3'h3)
		|=> ist_q[IRQ_RX] && rxf_full) else $error("rx four-level event missed");
	a_rx_three: assert property ((rx_done && rxisel_q == 2'h2 && rxf_cnt == 3'h1)
		|=> !$rose(ist_q[IRQ_RX])) else $error("rx three-level event too early");
	a_rx_any: assert property ((rx_done && !rxisel_q[1] && !rxf_full)
		|=> ist_q[IRQ_RX] && !rxf_empty) else $error("rx any-char event missed");
	a_bit12_zero: assert property (reg_rd |=> !reg_rdata[B_RSVD12])
		else $error("bit 12 read as one");
	a_overrun_set: assert property ((rx_done && rxf_full)
		|=> rx_overrun_flag_q ##1 (rx_overrun_flag_q || $past(wr_sta)))
		else $error("overrun flag not held");
	a_rx_avail: assert property ((reg_rd && reg_addr == ADR_STA)
		|=> reg_rdata[B_RXDA] == $past(rxf_cnt != 3'h0)) else $error("data-available flag wrong");

	c_break_sent: cover property (brk_done);
	c_rx_overrun: cover property (rx_done && rxf_full);
	c_tx_drain: cover property (frame_done && txf_empty);
endmodule

// ---- verification/usc_peer.sv ----
//-----------------------------------------------------------------------------
// Purpose: remote serial transceiver facing the block's serial pins
// Assumes: 8N1 frames, lsb first, 16 clocks per bit
// Notes: released line rests at its pull-up level, high
//-----------------------------------------------------------------------------
`timescale 1ns/100ps
module usc_peer (
	input wire logic clk,
	output logic line_out,
	input wire logic line_in
);
	// ----------------------------------------
	// sender
	// ----------------------------------------
	initial line_out = 1'b1;

	// one frame: start, 8 data lsb first, stop
	task automatic send(input logic [7:0] c);
		logic [9:0] f;
		f = {1'b1, c, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			line_out <= f[i];
			repeat (15) @(posedge clk);
		end
		repeat (4) @(posedge clk);
	endtask

	// ----------------------------------------
	// receiver
	// ----------------------------------------
	// waits for a start edge, then samples n bits at mid-bit
	task automatic catch(input int n, output logic [13:0] b);
		int t;
		b = '0;
		t = 0;
		while (line_in !== 1'b0 && t < 400) begin
			@(posedge clk);
			t++;
		end
		repeat (8) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			b[i] = line_in;
			repeat (16) @(posedge clk);
		end
	endtask
endmodule

// ---- verification/tb_top.sv ----
//-----------------------------------------------------------------------------
// Purpose: self-checking bench for the serial status/control block
// Assumes: 250 MHz clock, registers on the strobe port
// Notes: one task per scenario, peer model on the serial pins
//-----------------------------------------------------------------------------
`timescale 1ns/100ps
module tb_top;
	import usc_pkg::*;
	logic clk = 1'b0;
	logic sys_rst;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [DATA_W-1:0] reg_rdata;
	logic rx_line;
	logic serial_tx_pin;
	logic serial_tx_oe;
	logic irq;
	int err_count = 0;
	int n_checks = 0;

	// ----------------------------------------
	// clock, design and peer
	// ----------------------------------------
	always #2 clk = ~clk;

	usc_top uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_rx_pin(rx_line),
		.serial_tx_pin(serial_tx_pin), .serial_tx_oe(serial_tx_oe), .irq(irq));

	usc_peer peer (.clk(clk), .line_out(rx_line), .line_in(serial_tx_pin));

	// ----------------------------------------
	// bus and compare helpers
	// ----------------------------------------
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		// let the write settle before anyone looks at its effect
		#1;
	endtask

	// data are taken in the single cycle after the strobe
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// reset image, reserved bit, unmapped index
	task automatic t_reset();
		logic [15:0] d;
		rd(ADR_STA, d);
		chk(d, 16'h0110);
		chk({14'h0, serial_tx_oe, irq}, 16'h0000);
		wr(ADR_STA, 16'hffff);
		rd(ADR_STA, d);
		chk(d & 16'h1000, 16'h0000);
		wr(ADR_STA, 16'h0000);
		rd(3'h7, d);
		chk(d, 16'h0000);
	endtask

	// every tx event mode, early check then after frame end
	task automatic t_txmodes();
		logic [15:0] d;
		wr(ADR_IMSK, 16'h0001);
		for (int m = 0; m < 4; m++) begin
			wr(ADR_STA, {m[1], 1'b0, m[0], 13'h0400});
			wr(ADR_IST, 16'h0007);
			wr(ADR_TXD, 16'h0055);
			repeat (8) @(posedge clk);
			rd(ADR_IST, d);
			chk(d & 16'h0001, {15'h0, m == 0 || m == 2});
			repeat (170) @(posedge clk);
			rd(ADR_IST, d);
			chk(d & 16'h0001, {15'h0, m != 3});
			chk({15'h0, irq}, {15'h0, m != 3});
		end
		wr(ADR_IMSK, 16'h0000);
		wr(ADR_IST, 16'h0007);
	endtask

	// one data frame on the pin
	task automatic t_frame();
		logic [15:0] d;
		logic [13:0] b;
		wr(ADR_STA, 16'h0400);
		wr(ADR_TXD, 16'h00a5);
		rd(ADR_STA, d);
		chk(d & 16'h0100, 16'h0000);
		peer.catch(10, b);
		chk({6'h0, b[9:0]}, {6'h0, 1'b1, 8'ha5, 1'b0});
		repeat (20) @(posedge clk);
		rd(ADR_STA, d);
		chk(d & 16'h0100, 16'h0100);
	endtask

	// break frame, then the request reads back cleared
	task automatic t_break();
		logic [15:0] d;
		logic [13:0] b;
		wr(ADR_STA, 16'h0c00);
		peer.catch(14, b);
		chk({2'b00, b}, 16'h2000);
		repeat (20) @(posedge clk);
		rd(ADR_STA, d);
		chk(d & 16'h0800, 16'h0000);
	endtask

	// idle level for each polarity and encoding choice
	task automatic t_pol();
		logic inv;
		logic ir;
		for (int i = 0; i < 4; i++) begin
			inv = i[1];
			ir = i[0];
			wr(ADR_CFG, {15'h0, ir});
			wr(ADR_STA, {1'b0, inv, 14'h0400});
			repeat (4) @(posedge clk);
			chk({15'h0, serial_tx_pin}, {15'h0, ir ? inv : !inv});
			chk({15'h0, serial_tx_oe}, 16'h0001);
		end
		wr(ADR_CFG, 16'h0000);
	endtask

	// fill the buffer, then abort by clearing the enable
	task automatic t_full();
		logic [15:0] d;
		wr(ADR_STA, 16'h0400);
		for (int i = 0; i < 6; i++)
			wr(ADR_TXD, 16'h0030 + 16'(i));
		rd(ADR_STA, d);
		chk(d & 16'h0300, 16'h0200);
		wr(ADR_STA, 16'h0000);
		repeat (3) @(posedge clk);
		rd(ADR_STA, d);
		chk(d & 16'h0700, 16'h0100);
		chk({14'h0, serial_tx_oe, serial_tx_pin}, 16'h0001);
	endtask

	// receive events per mode, overrun and drain
	task automatic t_rx();
		logic [15:0] d;
		wr(ADR_STA, 16'h0040);
		wr(ADR_IST, 16'h0007);
		wr(ADR_IMSK, 16'h0002);
		peer.send(8'h3c);
		rd(ADR_STA, d);
		chk(d & 16'h0001, 16'h0001);
		chk({15'h0, irq}, 16'h0001);
		rd(ADR_RXD, d);
		chk(d & 16'h00ff, 16'h003c);
		rd(ADR_STA, d);
		chk(d & 16'h0001, 16'h0000);
		wr(ADR_IST, 16'h0007);
		chk({15'h0, irq}, 16'h0000);
		wr(ADR_STA, 16'h0080);
		peer.send(8'h01);
		peer.send(8'h02);
		rd(ADR_IST, d);
		chk(d & 16'h0002, 16'h0000);
		peer.send(8'h03);
		rd(ADR_IST, d);
		chk(d & 16'h0002, 16'h0002);
		wr(ADR_IST, 16'h0007);
		wr(ADR_STA, 16'h00c0);
		peer.send(8'h04);
		rd(ADR_IST, d);
		chk(d & 16'h0002, 16'h0002);
		peer.send(8'h05);
		rd(ADR_STA, d);
		chk(d & 16'h0002, 16'h0002);
		wr(ADR_STA, 16'h00c0);
		rd(ADR_STA, d);
		chk(d & 16'h0002, 16'h0000);
		for (int i = 1; i < 5; i++) begin
			rd(ADR_RXD, d);
			chk(d & 16'h00ff, 16'(i));
		end
	endtask

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		sys_rst <= 1'b1;
		reg_addr <= '0;
		reg_wdata <= '0;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset();
		t_txmodes();
		t_frame();
		t_break();
		t_pol();
		t_full();
		t_rx();
		close_out();
	end

	initial begin
		#40000;
		err_count++;
		close_out();
	end
endmodule
